// ===== shared/watchdog_pkg.sv
// Purpose : Shared constants and types of the window watchdog.
// Assumes : One core clock; registers one per aligned 32-bit word.
// Notes   : Register offsets are word indices; byte address is four times the index.
`default_nettype none

package watchdog_pkg;

  // ****************************************************************
  // Register map (word indices)
  // ****************************************************************
  localparam logic [3:0] CTRL_IDX    = 4'h8;  // Watchdog control
  localparam logic [3:0] SERVICE_IDX = 4'hb;  // Watchdog service (key port)
  localparam logic [3:0] STATUS_IDX  = 4'hc;  // Sticky event status
  localparam logic [3:0] MASK_IDX    = 4'hd;  // Interrupt mask

  // ****************************************************************
  // Control field positions and reset value
  // ****************************************************************
  localparam int         CTRL_WINDOW_BIT = 7;
  localparam int         CTRL_HALT_BIT   = 6;
  localparam int         CTRL_MASK_BIT   = 5;
  localparam int         CTRL_RATE_LSB   = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;  // Plain default
  localparam logic [2:0] RATE_OFF        = 3'h0;

  // ****************************************************************
  // Service keys
  // ****************************************************************
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ****************************************************************
  // Status and mask bit positions
  // ****************************************************************
  localparam int         EV_W        = 4;
  localparam int         EV_TIMEOUT  = 0;  // Period ran out
  localparam int         EV_BADKEY   = 1;  // Wrong service value
  localparam int         EV_WINDOW   = 2;  // Service write too early
  localparam int         EV_SERVICED = 3;  // Key pair completed
  localparam logic [3:0] MASK_RESET  = 4'h0;

  // ****************************************************************
  // Timer sizing
  // ****************************************************************
  localparam int EXP_W = 5;   // Width of a period exponent
  localparam int CNT_W = 25;  // Holds counts up to two to the 24th

endpackage : watchdog_pkg

`default_nettype wire

// ===== shared/timer_if.sv
// Purpose : Link between watchdog control logic and its period timer.
// Assumes : Both ends on the same clock.
// Notes   : ctl drives settings, tmr reports window and expiry.
`default_nettype none

interface timer_if;
  import watchdog_pkg::*;
  logic             enable;     // Counter running
  logic             restart;    // Start a fresh period
  logic             freeze;     // Hold count during debug halt
  logic [EXP_W-1:0] exp;        // Period is two to this power
  logic             in_window;  // Last quarter of the period reached
  logic             expired;    // One-cycle pulse at end of period

  modport ctl (output enable, restart, freeze, exp, input in_window, expired);
  modport tmr (input enable, restart, freeze, exp, output in_window, expired);
endinterface : timer_if

`default_nettype wire

// ===== src/watchdog_timer.sv
// Purpose : Period counter of the watchdog, counted in oscillator ticks.
// Assumes : Oscillator rate is the core clock divided by OSC_DIV.
// Notes   : Restart wins over freeze so a service in debug halt still counts.
`default_nettype none

module watchdog_timer
  import watchdog_pkg::*;
#(
  parameter int OSC_DIV = 1  // Core cycles per oscillator cycle
) (
  input  wire logic clk,     // Core clock
  input  wire logic arst_n,  // Asynchronous reset, active low
  timer_if.tmr      tif      // Settings in, window and expiry out
);

  typedef struct packed {
    logic [7:0]       div;
    logic [CNT_W-1:0] count;
    logic             expired;
  } tmr_state_t;

  tmr_state_t state_reg;
  tmr_state_t state_next;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] open_at;

  // ****************************************************************
  // Period arithmetic
  // ****************************************************************
  // Window opens once three quarters of the period are used up
  assign period        = CNT_W'(1) << tif.exp;
  assign open_at       = period - (period >> 2);
  assign tif.in_window = (state_reg.count >= open_at);
  assign tif.expired   = state_reg.expired;

  // Count oscillator ticks since the latest restart
  always_comb begin
    state_next         = state_reg;
    state_next.expired = 1'b0;
    if (tif.restart || !tif.enable) begin
      state_next.div   = 8'h00;
      state_next.count = '0;
    end else if (!tif.freeze) begin
      if (state_next.div == 8'(OSC_DIV - 1)) begin
        state_next.div = 8'h00;
        if (state_reg.count == period - CNT_W'(1)) begin
          state_next.expired = 1'b1;
          state_next.count   = '0;
        end else begin
          state_next.count = state_reg.count + CNT_W'(1);
        end
      end else begin
        state_next.div = state_reg.div + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : watchdog_timer

`default_nettype wire

// ===== src/window_watchdog_control.sv
// Purpose : Window watchdog control, service key checker and register slave.
// Assumes : Avalon-MM slave with byte addresses; registers in the low byte lane.
// Notes   : Mode and debug pins are asynchronous and pass two flip-flops.
//
// Operation
// - Control register reads back its current fields at any time.
// - Debug-halt bit writes freely in special modes, otherwise only sets.
// - Window bit and rate write freely in special modes, else only once.
// - In normal modes zero rate or zero window is ignored but uses the write.
// - Period restarts on accepted nonzero rate unmasked, or debug-halt rising.
// - In window mode a service write in the first 75% resets the system.
// - First key may repeat in window; second key restarts, then wait again.
// - Debug-halt set freezes watchdog and tick counters while debug is active.
// - Write-mask bit is write-only and shields window and rate from that write.
// - Nonzero rate enables counting; reaching period end raises system reset.
// - Enabled, debug, no halt, special or emulation: longest period, no window.
// - Rate 000 off; 001-101 two to 14..22 by twos; 110 to 23; 111 to 24.
// - Time-out counts oscillator cycles from the most recent restart.
// - Service register at index 0x000B reads zero and writes any time.
// - Service writes are ignored while the rate is zero.
// - Any service value other than the two keys resets at once when enabled.
//
// Local design decision: the Avalon-MM slave port.
`default_nettype none

module window_watchdog_control
  import watchdog_pkg::*;
#(
  parameter int OSC_DIV   = 1,   // Core cycles per oscillator cycle
  parameter int RATE1_EXP = 14,  // Period exponents, shorten for simulation
  parameter int RATE2_EXP = 16,
  parameter int RATE3_EXP = 18,
  parameter int RATE4_EXP = 20,
  parameter int RATE5_EXP = 22,
  parameter int RATE6_EXP = 23,
  parameter int RATE7_EXP = 24
) (
  input  wire logic        CORE_CLK,         // Core clock, 25 MHz
  input  wire logic        ARST_N,           // Asynchronous reset, active low
  input  wire logic [5:0]  AVS_ADDRESS,      // Byte address
  input  wire logic        AVS_READ,         // Read request
  input  wire logic        AVS_WRITE,        // Write request
  input  wire logic [31:0] AVS_WRITEDATA,    // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE,   // Byte lanes
  output logic      [31:0] AVS_READDATA,     // Read data
  output logic             AVS_WAITREQUEST,  // High while request not done
  input  wire logic        SPECIAL_MODE,     // Special mode pin
  input  wire logic        EMUL_MODE,        // Emulation mode pin
  input  wire logic        DEBUG_ACTIVE,     // Active background debug
  output logic             SYS_RESET_REQ,    // System reset request pulse
  output logic             TICK_FREEZE,      // Freeze for periodic tick counter
  output logic             IRQ               // Level interrupt
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]      special_sync;  // Mode pin synchroniser
    logic [1:0]      emul_sync;     // Emulation pin synchroniser
    logic [1:0]      debug_sync;    // Debug pin synchroniser
    logic            window;        // Window mode
    logic            halt;          // Debug-halt select
    logic [2:0]      rate;          // Time-out rate
    logic            once_used;     // Single normal-mode write spent
    logic            armed;         // First key seen
    logic            restart;       // Restart request to the timer
    logic            reset_req;     // System reset pulse
    logic            tick_freeze;   // Periodic tick freeze
    logic            waitreq;       // Bus wait
    logic [31:0]     rdata;         // Bus read data
    logic [EV_W-1:0] status;        // Sticky events
    logic [EV_W-1:0] mask;          // Interrupt enables
    logic            irq;           // Interrupt output
  } ctl_state_t;

  ctl_state_t s_reg;
  ctl_state_t s_next;
  timer_if    tif ();

  logic            special;
  logic            emul;
  logic            debug;
  logic            enabled;
  logic            override;
  logic            access;
  logic            do_write;
  logic            do_read;
  logic [3:0]      index;
  logic [7:0]      wbyte;
  logic [EV_W-1:0] events;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Rate field to period exponent
  function automatic logic [EXP_W-1:0] rate_exp(input logic [2:0] rate);
    logic [EXP_W-1:0] e;
    e = EXP_W'(RATE7_EXP);
    case (rate)
      3'h1: e = EXP_W'(RATE1_EXP);
      3'h2: e = EXP_W'(RATE2_EXP);
      3'h3: e = EXP_W'(RATE3_EXP);
      3'h4: e = EXP_W'(RATE4_EXP);
      3'h5: e = EXP_W'(RATE5_EXP);
      3'h6: e = EXP_W'(RATE6_EXP);
      default: e = EXP_W'(RATE7_EXP);
    endcase
    return e;
  endfunction : rate_exp

  // Control register image as software reads it
  function automatic logic [7:0] ctrl_image(input logic w, input logic h,
                                            input logic [2:0] r);
    logic [7:0] v;
    v                  = 8'h00;  // Mask bit and unused bits stay zero
    v[CTRL_WINDOW_BIT] = w;
    v[CTRL_HALT_BIT]   = h;
    v[CTRL_RATE_LSB +: 3] = r;
    return v;
  endfunction : ctrl_image

  // ****************************************************************
  // Decoded conditions
  // ****************************************************************
  // Synchronised pins, read only from the second stage
  assign special  = s_reg.special_sync[1];
  assign emul     = s_reg.emul_sync[1];
  assign debug    = s_reg.debug_sync[1];
  assign enabled  = (s_reg.rate != RATE_OFF);
  assign override = enabled && debug && !s_reg.halt && (special || emul);

  // One wait cycle, then the request completes on the edge with wait low
  assign access   = (AVS_READ || AVS_WRITE) && !s_reg.waitreq;
  assign do_write = access && AVS_WRITE && AVS_BYTEENABLE[0];
  assign do_read  = access && AVS_READ;
  assign index    = AVS_ADDRESS[5:2];
  assign wbyte    = AVS_WRITEDATA[7:0];

  // ****************************************************************
  // Timer connection
  // ****************************************************************
  // Debug override forces the longest period with the window off
  assign tif.enable  = enabled;
  assign tif.restart = s_reg.restart;
  assign tif.freeze  = s_reg.halt && debug;
  assign tif.exp     = override ? EXP_W'(RATE7_EXP) : rate_exp(s_reg.rate);

  watchdog_timer #(
    .OSC_DIV (OSC_DIV)
  ) u_timer (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .tif    (tif)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Register writes, service checking and event collection
  always_comb begin
    s_next              = s_reg;
    events              = '0;
    s_next.special_sync = {s_reg.special_sync[0], SPECIAL_MODE};
    s_next.emul_sync    = {s_reg.emul_sync[0], EMUL_MODE};
    s_next.debug_sync   = {s_reg.debug_sync[0], DEBUG_ACTIVE};
    s_next.restart      = 1'b0;
    s_next.reset_req    = 1'b0;
    s_next.tick_freeze  = s_reg.halt && debug;
    s_next.waitreq      = 1'b1;

    // Bus handshake: drop wait for one cycle after a request is seen
    if ((AVS_READ || AVS_WRITE) && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
    end

    // Read data are captured in the wait cycle so they stand at the done edge
    if (AVS_READ && s_reg.waitreq) begin
      case (index)
        CTRL_IDX:    s_next.rdata = {24'h000000,
                                     ctrl_image(s_reg.window, s_reg.halt, s_reg.rate)};
        SERVICE_IDX: s_next.rdata = 32'h00000000;
        STATUS_IDX:  s_next.rdata = {28'h0000000, s_reg.status};
        MASK_IDX:    s_next.rdata = {28'h0000000, s_reg.mask};
        default:     s_next.rdata = 32'h00000000;
      endcase
    end

    // Control register write
    if (do_write && index == CTRL_IDX) begin
      if (special) begin
        s_next.halt = wbyte[CTRL_HALT_BIT];
      end else begin
        s_next.halt = s_reg.halt | wbyte[CTRL_HALT_BIT];
      end
      if (!s_reg.halt && s_next.halt) begin
        s_next.restart = 1'b1;
      end
      // Mask bit shields window and rate, and spends nothing
      if (!wbyte[CTRL_MASK_BIT] && (special || !s_reg.once_used)) begin
        if (special || wbyte[CTRL_RATE_LSB +: 3] != RATE_OFF) begin
          s_next.rate = wbyte[CTRL_RATE_LSB +: 3];
        end
        if (special || wbyte[CTRL_WINDOW_BIT]) begin
          s_next.window = wbyte[CTRL_WINDOW_BIT];
        end
        if (!special) begin
          s_next.once_used = 1'b1;
        end
        if (wbyte[CTRL_RATE_LSB +: 3] != RATE_OFF) begin
          s_next.restart = 1'b1;
          s_next.armed   = 1'b0;
        end
      end
    end

    // Service register write, ignored while the watchdog is off
    if (do_write && index == SERVICE_IDX && enabled) begin
      if (s_reg.window && !override && !tif.in_window) begin
        events[EV_WINDOW] = 1'b1;
      end else if (wbyte == KEY_FIRST) begin
        s_next.armed = 1'b1;
      end else if (wbyte == KEY_SECOND) begin
        if (s_reg.armed) begin
          s_next.armed          = 1'b0;
          s_next.restart        = 1'b1;
          events[EV_SERVICED]   = 1'b1;
        end
      end else begin
        events[EV_BADKEY] = 1'b1;
      end
    end

    // Period ran out without a completed key pair
    if (tif.expired) begin
      events[EV_TIMEOUT] = 1'b1;
    end

    // Any fault raises a one-cycle reset pulse and restarts the count
    if (events[EV_TIMEOUT] || events[EV_BADKEY] || events[EV_WINDOW]) begin
      s_next.reset_req = 1'b1;
      s_next.restart   = 1'b1;
      s_next.armed     = 1'b0;
    end

    // Mask register write
    if (do_write && index == MASK_IDX) begin
      s_next.mask = wbyte[EV_W-1:0];
    end

    // Read of status clears only the bits that were reported, new events win
    if (do_read && index == STATUS_IDX) begin
      s_next.status = s_reg.status & ~s_reg.rdata[EV_W-1:0];
    end
    s_next.status = s_next.status | events;

    // Level interrupt from unmasked sticky bits
    s_next.irq = |(s_next.status & s_next.mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset loads constants only; pins are caught later by the synchronisers
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg           <= '0;
      s_reg.window    <= CTRL_RESET[CTRL_WINDOW_BIT];
      s_reg.halt      <= CTRL_RESET[CTRL_HALT_BIT];
      s_reg.rate      <= CTRL_RESET[CTRL_RATE_LSB +: 3];
      s_reg.waitreq   <= 1'b1;
      s_reg.mask      <= MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a flip-flop of the state
  assign AVS_READDATA    = s_reg.rdata;
  assign AVS_WAITREQUEST = s_reg.waitreq;
  assign SYS_RESET_REQ   = s_reg.reset_req;
  assign TICK_FREEZE     = s_reg.tick_freeze;
  assign IRQ             = s_reg.irq;

endmodule : window_watchdog_control

`default_nettype wire

// ===== tb/wdg_ctl_sva.sv
// Purpose: Port checker of the window watchdog control block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   The rate is learnt from control reads only, so writes forget it.
`default_nettype none

module wdg_ctl_sva
  import watchdog_pkg::*;
(
  input wire logic        CORE_CLK,         // Clock
  input wire logic        ARST_N,           // Reset, active low
  input wire logic [5:0]  AVS_ADDRESS,      // Byte address
  input wire logic        AVS_READ,         // Read request
  input wire logic        AVS_WRITE,        // Write request
  input wire logic [31:0] AVS_WRITEDATA,    // Write data
  input wire logic [3:0]  AVS_BYTEENABLE,   // Byte lanes
  input wire logic [31:0] AVS_READDATA,     // Read data
  input wire logic        AVS_WAITREQUEST,  // Wait
  input wire logic        DEBUG_ACTIVE,     // Debug pin
  input wire logic        SYS_RESET_REQ,    // Reset request
  input wire logic        TICK_FREEZE       // Tick freeze
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // ********
  // Helper state
  // ********
  logic       known_reg;  // A control read seen since the last control write
  logic [2:0] rate_reg;   // Rate field of that read
  wire logic  done  = !AVS_WAITREQUEST;
  wire logic  ctl   = AVS_ADDRESS[5:2] == CTRL_IDX;
  wire logic  svc_w = AVS_WRITE && done && AVS_ADDRESS[5:2] == SERVICE_IDX && AVS_BYTEENABLE[0];
  wire logic  bad   = AVS_WRITEDATA[7:0] != KEY_FIRST && AVS_WRITEDATA[7:0] != KEY_SECOND;

  // A write may be ignored, so forgetting the rate is the safe side
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      known_reg <= 1'b0;
      rate_reg  <= 3'h0;
    end else if (done && ctl && AVS_WRITE) begin
      known_reg <= 1'b0;
    end else if (done && ctl && AVS_READ) begin
      known_reg <= 1'b1;
      rate_reg  <= AVS_READDATA[2:0];
    end
  end

  // ********
  // Assertions
  // ********
  chk_bus_answer: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("bus request not answered");
  chk_bus_idle: assert property (
    !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
    else $error("wait low without request");
  chk_svc_reads: assert property (
    AVS_READ && done && AVS_ADDRESS[5:2] == SERVICE_IDX |-> AVS_READDATA == 32'h0)
    else $error("service read not zero");
  chk_ctrl_zeros: assert property (
    AVS_READ && done && ctl |-> AVS_READDATA[31:8] == 24'h0 && AVS_READDATA[5:3] == 3'h0)
    else $error("control read shows unused bits");
  chk_pulse_once: assert property (
    SYS_RESET_REQ |=> !SYS_RESET_REQ)
    else $error("reset request longer than one cycle");
  chk_bad_key: assert property (
    svc_w && bad && known_reg && rate_reg != RATE_OFF |=> SYS_RESET_REQ)
    else $error("wrong key gave no reset");
  chk_svc_ignored: assert property (
    svc_w && known_reg && rate_reg == RATE_OFF |=> (!SYS_RESET_REQ) [*3])
    else $error("service write acted while off");
  chk_freeze_off: assert property (
    (!DEBUG_ACTIVE) [*5] |-> !TICK_FREEZE)
    else $error("freeze without debug");
endmodule : wdg_ctl_sva

bind window_watchdog_control wdg_ctl_sva i_wdg_ctl_sva (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .DEBUG_ACTIVE(DEBUG_ACTIVE),
  .SYS_RESET_REQ(SYS_RESET_REQ), .TICK_FREEZE(TICK_FREEZE));

`default_nettype wire

// ===== tb/window_watchdog_control_bench.sv
// Purpose: Self-checking bench of the window watchdog control block.
// Assumes: Oscillator equals core clock; periods shortened to 2^6..2^12.
// Notes:   A control model mirrors the write-once and mask behaviour.
`default_nettype none

module window_watchdog_control_bench import watchdog_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int        EXPS [8] = '{0, 6, 7, 8, 9, 10, 11, 12};  // Shortened exponents
  localparam int        LIMIT    = 30000;  // Run ceiling in cycles
  localparam logic[5:0] CTL = {CTRL_IDX, 2'b00};
  localparam logic[5:0] SVC = {SERVICE_IDX, 2'b00};
  localparam logic[5:0] STA = {STATUS_IDX, 2'b00};
  localparam logic[5:0] MSK = {MASK_IDX, 2'b00};
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic [5:0]  address  = 6'h00;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  be       = 4'h1;
  logic        special  = 1'b0;
  logic        emul     = 1'b0;
  logic        debug    = 1'b0;
  wire logic [31:0] rdata;
  wire logic   waitreq, sys_rst, freeze, irq;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  m_ctrl;       // Model of the control register
  bit          m_once;       // Model: single write used up
  logic [7:0]  rnd = 8'h40;  // Random state
  logic [31:0] q;

  window_watchdog_control #(.RATE1_EXP(EXPS[1]), .RATE2_EXP(EXPS[2]), .RATE3_EXP(EXPS[3]),
    .RATE4_EXP(EXPS[4]), .RATE5_EXP(EXPS[5]), .RATE6_EXP(EXPS[6]), .RATE7_EXP(EXPS[7]))
  i_window_watchdog_control (.CORE_CLK(core_clk), .ARST_N(arst_n), .AVS_ADDRESS(address),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .SPECIAL_MODE(special),
    .EMUL_MODE(emul), .DEBUG_ACTIVE(debug), .SYS_RESET_REQ(sys_rst),
    .TICK_FREEZE(freeze), .IRQ(irq));

  // ********
  // Clock, guard and helpers
  // ********
  always #20 core_clk = ~core_clk;

  // A hang counts as a mismatch and ends the run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      summarize();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic void model_ctrl(input logic [7:0] d);
    if (special || d[6]) m_ctrl[6] = d[6];
    if (!d[5] && (special || !m_once)) begin
      if (special || d[7]) m_ctrl[7] = d[7];
      if (special || d[2:0] != 3'h0) m_ctrl[2:0] = d[2:0];
      m_once = 1'b1;
    end
  endfunction : model_ctrl

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : rng

  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    rd      <= !w;
    wr      <= w;
    address <= a;
    wdata   <= {24'h0, d};
    do begin
      @(posedge core_clk);
      t++;
    end while (waitreq !== 1'b0 && t < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (t >= 20) rng(t, 0, 19);
  endtask : bus

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(q, exp);
  endtask : rchk

  task automatic ctl(input logic [7:0] d);
    bus(1'b1, CTL, d);
    model_ctrl(d);
    rchk(CTL, {24'h0, m_ctrl});
  endtask : ctl

  task automatic wait_rst(input int maxc);
    n = -1;
    for (int i = 1; i <= maxc && n < 0; i++) begin
      @(posedge core_clk);
      if (sys_rst === 1'b1) n = i;
    end
  endtask : wait_rst

  task automatic bad_key();
    do rnd = lfsr(rnd); while (rnd == KEY_FIRST || rnd == KEY_SECOND);
    bus(1'b1, SVC, rnd);
  endtask : bad_key

  task automatic do_reset();
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    m_ctrl = CTRL_RESET;
    m_once = 1'b0;
  endtask : do_reset

  // ********
  // Main sequence
  // ********
  initial begin
    do_reset();
    // Reset values, unmapped place, refused lane, service while off
    rchk(CTL, 32'h0);
    rchk(SVC, 32'h0);
    bus(1'b1, 6'h04, 8'hff);
    rchk(6'h04, 32'h0);
    be <= 4'h0;
    bus(1'b1, CTL, 8'h01);
    be <= 4'h1;
    rchk(CTL, 32'h0);
    bad_key();
    wait_rst(8);
    rng(n, -1, -1);
    $display("test 1 done");
    // Normal-mode write rules on the control register
    // A masked write must leave the single write unspent, so the next one lands
    ctl(8'h63);
    ctl(8'h80);
    ctl(8'h01);
    $display("test 2 done");
    // Keep-alive by key pairs, then a wrong key
    do_reset();
    ctl(8'h01);
    ctl(8'h07);
    bus(1'b1, MSK, 8'h0a);
    rchk(MSK, 32'h0a);
    for (int i = 0; i < 4; i++) begin
      wait_rst(30);
      rng(n, -1, -1);
      bus(1'b1, SVC, KEY_SECOND);
      bus(1'b1, SVC, KEY_FIRST);
      bus(1'b1, SVC, KEY_FIRST);
      bus(1'b1, SVC, KEY_SECOND);
    end
    check({31'h0, irq}, 32'h1);
    rchk(CTL, 32'h01);
    bad_key();
    wait_rst(3);
    rng(n, 1, 1);
    rchk(STA, 32'h0a);
    repeat (3) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    $display("test 3 done");
    // Every rate, then window mode and debug halt in special mode
    do_reset();
    special <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int r = 1; r < 8; r++) begin
      ctl(r[7:0]);
      wait_rst((1 << EXPS[r]) + 10);
      rng(n, (1 << EXPS[r]) - 6, (1 << EXPS[r]) + 6);
    end
    ctl(8'h41);
    ctl(8'h81);
    rchk(STA, 32'h01);
    bus(1'b1, SVC, KEY_FIRST);
    wait_rst(3);
    rng(n, 1, 1);
    repeat (52) @(posedge core_clk);
    bus(1'b1, SVC, KEY_FIRST);
    bus(1'b1, SVC, KEY_SECOND);
    wait_rst(40);
    rng(n, -1, -1);
    rchk(STA, 32'h0c);
    ctl(8'h41);
    debug <= 1'b1;
    repeat (5) @(posedge core_clk);
    check({31'h0, freeze}, 32'h1);
    wait_rst(150);
    rng(n, -1, -1);
    debug <= 1'b0;
    wait_rst(80);
    rng(n, 1, 80);
    $display("test 4 done");
    // Debug override in emulation mode: no window, longest period
    do_reset();
    special <= 1'b0;
    emul    <= 1'b1;
    debug   <= 1'b1;
    repeat (3) @(posedge core_clk);
    ctl(8'h81);
    bus(1'b1, SVC, KEY_FIRST);
    wait_rst(200);
    rng(n, -1, -1);
    check({31'h0, freeze}, 32'h0);
    $display("test 5 done");
    summarize();
  end
endmodule : window_watchdog_control_bench

`default_nettype wire
